/* File: src/rpl_regs.sv */
// Reference profile level register bank behind a classic Wishbone slave port.
`timescale 1ns/1ns
// Function
// - Point B low bit at bit 30.
// - Point B upper seven bits in preceding register.
// - Point C level in bits 29 to 22.
// - Point D level in bits 21 to 14.
// - Point E level in bits 13 to 6.
// - Second turn-off level in bits 30 to 23.
// - Second clamp level in bits 22 to 15.
// - Off/clamp register cleared on reset.
// - Fault settings registers at their fixed offsets.
module rpl_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [7:0] POINT_B_LEVEL,
    output logic [7:0] POINT_C_LEVEL,
    output logic [7:0] POINT_D_LEVEL,
    output logic [7:0] POINT_E_LEVEL,
    output logic [7:0] SECOND_TURNOFF_LEVEL,
    output logic [7:0] SECOND_CLAMP_LEVEL
);
    localparam int IDX_W = ADDR_W - 2;

    logic [IDX_W-1:0] word_idx;
    logic bus_req;
    logic wb_commit;
    logic hit_fault_primary;
    logic hit_fault_secondary;
    logic hit_profile_prev;
    logic hit_points;
    logic hit_off_clamp;
    logic hit_none;
    logic [31:0] fault_settings_primary;
    logic [31:0] fault_settings_secondary;
    logic [31:0] profile_prev;
    logic [31:0] reference_points_b_to_e;
    logic [31:0] reference_off_clamp_levels;
    logic [31:0] next_rdat;

    // The two low address bits take no part in decode; byte lanes come from WB_SEL_I.
    assign word_idx = WB_ADR_I[ADDR_W-1:2];
    assign bus_req = WB_CYC_I & WB_STB_I;

    // Writes land on the edge that also samples ack, as the master expects.
    assign wb_commit = bus_req & WB_WE_I & WB_ACK_O;

    assign hit_fault_primary = word_idx == IDX_W'(rpl_pkg::IDX_FAULT_PRIMARY);
    assign hit_fault_secondary = word_idx == IDX_W'(rpl_pkg::IDX_FAULT_SECONDARY);
    assign hit_profile_prev = word_idx == IDX_W'(rpl_pkg::IDX_PROFILE_PREV);
    assign hit_points = word_idx == IDX_W'(rpl_pkg::IDX_POINTS);
    assign hit_off_clamp = word_idx == IDX_W'(rpl_pkg::IDX_OFF_CLAMP);
    assign hit_none = ~(hit_fault_primary | hit_fault_secondary | hit_profile_prev
        | hit_points | hit_off_clamp);

    rpl_wb_ack u_ack (
        .clk(CLK),
        .rst(RST),
        .cyc(WB_CYC_I),
        .stb(WB_STB_I),
        .ack(WB_ACK_O)
    );

    // Fault settings storage; the field meanings belong to the fault logic elsewhere.
    rpl_masked_reg #(
        .WRITE_MASK(rpl_pkg::MASK_FAULT),
        .RESET_VALUE(rpl_pkg::RESET_FAULT)
    ) u_fault_primary (
        .clk(CLK),
        .rst(RST),
        .we(wb_commit & hit_fault_primary),
        .sel(WB_SEL_I),
        .wdat(WB_DAT_I),
        .q(fault_settings_primary)
    );

    rpl_masked_reg #(
        .WRITE_MASK(rpl_pkg::MASK_FAULT),
        .RESET_VALUE(rpl_pkg::RESET_FAULT)
    ) u_fault_secondary (
        .clk(CLK),
        .rst(RST),
        .we(wb_commit & hit_fault_secondary),
        .sel(WB_SEL_I),
        .wdat(WB_DAT_I),
        .q(fault_settings_secondary)
    );

    // Preceding profile register; its low seven bits carry the top of point B.
    rpl_masked_reg #(
        .WRITE_MASK(rpl_pkg::MASK_PROFILE_PREV),
        .RESET_VALUE(rpl_pkg::RESET_PROFILE_PREV)
    ) u_profile_prev (
        .clk(CLK),
        .rst(RST),
        .we(wb_commit & hit_profile_prev),
        .sel(WB_SEL_I),
        .wdat(WB_DAT_I),
        .q(profile_prev)
    );

    // The mask keeps bit 31 and bits 5 to 0 at zero.
    rpl_masked_reg #(
        .WRITE_MASK(rpl_pkg::MASK_POINTS),
        .RESET_VALUE(rpl_pkg::RESET_POINTS)
    ) u_points (
        .clk(CLK),
        .rst(RST),
        .we(wb_commit & hit_points),
        .sel(WB_SEL_I),
        .wdat(WB_DAT_I),
        .q(reference_points_b_to_e)
    );

    // The mask keeps bit 31 and bits 14 to 0 at zero.
    rpl_masked_reg #(
        .WRITE_MASK(rpl_pkg::MASK_OFF_CLAMP),
        .RESET_VALUE(rpl_pkg::RESET_OFF_CLAMP)
    ) u_off_clamp (
        .clk(CLK),
        .rst(RST),
        .we(wb_commit & hit_off_clamp),
        .sel(WB_SEL_I),
        .wdat(WB_DAT_I),
        .q(reference_off_clamp_levels)
    );

    // Unmapped words answer with zero rather than no ack, so the bus never hangs.
    always_comb begin
        next_rdat = rpl_pkg::READ_UNMAPPED;
        if (hit_fault_primary) begin
            next_rdat = fault_settings_primary;
        end else if (hit_fault_secondary) begin
            next_rdat = fault_settings_secondary;
        end else if (hit_profile_prev) begin
            next_rdat = profile_prev;
        end else if (hit_points) begin
            next_rdat = reference_points_b_to_e;
        end else if (hit_off_clamp) begin
            next_rdat = reference_off_clamp_levels;
        end
    end

    // Read data is captured on the edge that raises ack and holds until the next request.
    always_ff @(posedge CLK) begin
        if (RST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (bus_req & ~WB_ACK_O) begin
            WB_DAT_O <= next_rdat;
        end
    end

    // Level outputs trail the stored fields by one cycle; they are flops, not decode.
    always_ff @(posedge CLK) begin
        if (RST) begin
            POINT_B_LEVEL <= 8'h00;
            POINT_C_LEVEL <= 8'h00;
            POINT_D_LEVEL <= 8'h00;
            POINT_E_LEVEL <= 8'h00;
            SECOND_TURNOFF_LEVEL <= 8'h00;
            SECOND_CLAMP_LEVEL <= 8'h00;
        end else begin
            POINT_B_LEVEL <= {profile_prev[rpl_pkg::POS_B_MSB +: rpl_pkg::B_MSB_W],
                reference_points_b_to_e[rpl_pkg::POS_B_LSB]};
            POINT_C_LEVEL <= reference_points_b_to_e[rpl_pkg::POS_C +: rpl_pkg::LEVEL_W];
            POINT_D_LEVEL <= reference_points_b_to_e[rpl_pkg::POS_D +: rpl_pkg::LEVEL_W];
            POINT_E_LEVEL <= reference_points_b_to_e[rpl_pkg::POS_E +: rpl_pkg::LEVEL_W];
            SECOND_TURNOFF_LEVEL <=
                reference_off_clamp_levels[rpl_pkg::POS_OFF2 +: rpl_pkg::LEVEL_W];
            SECOND_CLAMP_LEVEL <=
                reference_off_clamp_levels[rpl_pkg::POS_CLAMP2 +: rpl_pkg::LEVEL_W];
        end
    end

    default clocking cb @(posedge CLK);
    endclocking

    default disable iff (RST);

    sequence s_open_req;
        bus_req && !WB_ACK_O;
    endsequence

    sequence s_full_write(logic hit);
        wb_commit && hit && WB_SEL_I == 4'hF;
    endsequence

    sequence s_read(logic hit);
        s_open_req ##0 !WB_WE_I && hit;
    endsequence

    sequence s_quiet;
        !wb_commit [*2];
    endsequence

    // The master idles one cycle between transfers, so the read is taken two edges later.
    sequence s_readback(logic hit);
        s_full_write(hit) ##2 s_read(hit);
    endsequence

    a_ack_one_pulse: assert property (
        s_open_req |=> WB_ACK_O ##1 !WB_ACK_O
    ) else $error("Ack did not pulse for exactly one cycle.");

    a_ptb_lsb_store: assert property (
        s_full_write(hit_points) |=> ##1
            POINT_B_LEVEL[0] == $past(WB_DAT_I[30], 2)
    ) else $error("Point B low bit did not follow bit 30.");

    a_ptb_upper_join: assert property (
        s_full_write(hit_profile_prev) |=> ##1
            POINT_B_LEVEL[7:1] == $past(WB_DAT_I[6:0], 2)
    ) else $error("Point B upper bits did not follow bits 6 to 0.");

    a_ptc_level: assert property (
        s_full_write(hit_points) |=> ##1
            POINT_C_LEVEL == $past(WB_DAT_I[29:22], 2)
    ) else $error("Point C level did not follow bits 29 to 22.");

    a_ptd_level: assert property (
        s_full_write(hit_points) |=> ##1
            POINT_D_LEVEL == $past(WB_DAT_I[21:14], 2)
    ) else $error("Point D level did not follow bits 21 to 14.");

    a_pte_level: assert property (
        s_full_write(hit_points) |=> ##1
            POINT_E_LEVEL == $past(WB_DAT_I[13:6], 2)
    ) else $error("Point E level did not follow bits 13 to 6.");

    a_off2_level: assert property (
        s_full_write(hit_off_clamp) |=> ##1
            SECOND_TURNOFF_LEVEL == $past(WB_DAT_I[30:23], 2)
    ) else $error("Second turn-off level did not follow bits 30 to 23.");

    a_clamp2_level: assert property (
        s_full_write(hit_off_clamp) |=> ##1
            SECOND_CLAMP_LEVEL == $past(WB_DAT_I[22:15], 2)
    ) else $error("Second clamp level did not follow bits 22 to 15.");

    a_offclamp_reset: assert property (
        @(posedge CLK) disable iff (1'b0)
        RST |=> reference_off_clamp_levels == 32'h0000_0000 && SECOND_CLAMP_LEVEL == 8'h00
    ) else $error("Off/clamp register not cleared by reset.");

    a_fault_primary_map: assert property (
        s_read(hit_fault_primary) |=> WB_ACK_O && WB_DAT_O == fault_settings_primary
    ) else $error("Primary fault settings not returned at its offset.");

    a_fault_secondary_map: assert property (
        s_read(hit_fault_secondary) |=> WB_ACK_O && WB_DAT_O == fault_settings_secondary
    ) else $error("Secondary fault settings not returned at its offset.");

    a_reserved_zero: assert property (
        s_full_write(hit_points) |=> reference_points_b_to_e[31] == 1'b0
            && reference_points_b_to_e[5:0] == 6'h00
            && reference_off_clamp_levels[31] == 1'b0
            && reference_off_clamp_levels[14:0] == 15'h0000
    ) else $error("A reserved bit was set.");

    a_points_readback: assert property (
        s_readback(hit_points) |=>
            WB_DAT_O == ($past(WB_DAT_I, 3) & 32'h7FFF_FFC0)
    ) else $error("Points readback differs from masked write data.");

    a_prev_readback: assert property (
        s_readback(hit_profile_prev) |=>
            WB_DAT_O == ($past(WB_DAT_I, 3) & 32'h7FFF_FFFF)
    ) else $error("Preceding profile readback differs from write data.");

    a_offclamp_readback: assert property (
        s_readback(hit_off_clamp) |=>
            WB_DAT_O == ($past(WB_DAT_I, 3) & 32'h7FFF_8000)
    ) else $error("Off/clamp readback differs from masked write data.");

    a_primary_readback: assert property (
        s_readback(hit_fault_primary) |=>
            WB_DAT_O == ($past(WB_DAT_I, 3) & 32'h7FFF_FFFF)
    ) else $error("Primary fault settings readback differs from write data.");

    a_secondary_readback: assert property (
        s_readback(hit_fault_secondary) |=>
            WB_DAT_O == ($past(WB_DAT_I, 3) & 32'h7FFF_FFFF)
    ) else $error("Secondary fault settings readback differs from write data.");

    a_offclamp_reserved: assert property (
        s_full_write(hit_off_clamp) |=> reference_off_clamp_levels[31] == 1'b0
            && reference_off_clamp_levels[14:0] == 15'h0000
    ) else $error("A reserved off/clamp bit was set.");

    a_unmapped_read: assert property (
        s_read(hit_none) |=> WB_DAT_O == 32'h0000_0000
    ) else $error("An unmapped word did not read zero.");

    a_unmapped_write: assert property (
        s_full_write(hit_none) |=> $stable(fault_settings_primary)
            && $stable(fault_settings_secondary) && $stable(profile_prev)
            && $stable(reference_points_b_to_e) && $stable(reference_off_clamp_levels)
    ) else $error("A write to an unmapped word changed a register.");

    a_decode_apart: assert property (
        s_full_write(hit_off_clamp) |=> $stable(reference_points_b_to_e)
            && $stable(profile_prev) && $stable(fault_settings_primary)
            && $stable(fault_settings_secondary)
    ) else $error("An off/clamp write disturbed another register.");

    a_lane_keep: assert property (
        wb_commit && hit_points && WB_SEL_I == 4'h3
            |=> reference_points_b_to_e[31:16] == $past(reference_points_b_to_e[31:16])
    ) else $error("A disabled byte lane was written.");

    a_lane_load: assert property (
        wb_commit && hit_points && WB_SEL_I == 4'h3
            |=> reference_points_b_to_e[15:0] == ($past(WB_DAT_I[15:0]) & 16'hFFC0)
    ) else $error("An enabled byte lane did not load its masked data.");

    a_levels_hold: assert property (
        s_quiet |=> $stable(POINT_B_LEVEL) && $stable(POINT_C_LEVEL)
            && $stable(POINT_D_LEVEL) && $stable(POINT_E_LEVEL)
            && $stable(SECOND_TURNOFF_LEVEL) && $stable(SECOND_CLAMP_LEVEL)
    ) else $error("A level output moved with no register write.");

    a_levels_reset: assert property (
        @(posedge CLK) disable iff (1'b0)
        RST |=> POINT_B_LEVEL == 8'h00 && POINT_C_LEVEL == 8'h00 && POINT_D_LEVEL == 8'h00
            && POINT_E_LEVEL == 8'h00 && SECOND_TURNOFF_LEVEL == 8'h00
            && SECOND_CLAMP_LEVEL == 8'h00
    ) else $error("Level outputs not cleared by reset.");

    a_regs_reset: assert property (
        @(posedge CLK) disable iff (1'b0)
        RST |=> fault_settings_primary == 32'h0000_0000
            && fault_settings_secondary == 32'h0000_0000
            && profile_prev == 32'h0000_0000
            && reference_points_b_to_e == 32'h0000_0000
            && WB_ACK_O == 1'b0 && WB_DAT_O == 32'h0000_0000
    ) else $error("Registers or bus outputs not cleared by reset.");

    a_ack_no_req: assert property (
        !bus_req |=> !WB_ACK_O
    ) else $error("Ack rose without an open request.");

    a_rdat_hold: assert property (
        !(bus_req && !WB_ACK_O) |=> $stable(WB_DAT_O)
    ) else $error("Read data changed between requests.");
endmodule // rpl_regs

/* File: include/rpl_pkg.sv */
// Package with the map and field layout of the reference profile level registers.
package rpl_pkg;
    // Register indices; the byte address of each is four times its index.
    localparam int unsigned IDX_FAULT_PRIMARY = 32'h0000_0090;
    localparam int unsigned IDX_FAULT_SECONDARY = 32'h0000_0092;
    localparam int unsigned IDX_PROFILE_PREV = 32'h0000_009A;
    localparam int unsigned IDX_POINTS = 32'h0000_009C;
    localparam int unsigned IDX_OFF_CLAMP = 32'h0000_009E;

    // Writable bits of each register; every other bit is reserved and reads zero.
    localparam logic [31:0] MASK_FAULT = 32'h7FFF_FFFF;
    localparam logic [31:0] MASK_PROFILE_PREV = 32'h7FFF_FFFF;
    localparam logic [31:0] MASK_POINTS = 32'h7FFF_FFC0;
    localparam logic [31:0] MASK_OFF_CLAMP = 32'h7FFF_8000;

    // Values after reset, and the value that an unmapped word reads.
    localparam logic [31:0] RESET_FAULT = 32'h0000_0000;
    localparam logic [31:0] RESET_PROFILE_PREV = 32'h0000_0000;
    localparam logic [31:0] RESET_POINTS = 32'h0000_0000;
    localparam logic [31:0] RESET_OFF_CLAMP = 32'h0000_0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // Field positions.
    localparam int unsigned LEVEL_W = 8;
    localparam int unsigned B_MSB_W = 7;
    localparam int unsigned POS_B_MSB = 0;
    localparam int unsigned POS_B_LSB = 30;
    localparam int unsigned POS_C = 22;
    localparam int unsigned POS_D = 14;
    localparam int unsigned POS_E = 6;
    localparam int unsigned POS_OFF2 = 23;
    localparam int unsigned POS_CLAMP2 = 15;
endpackage

/* File: src/rpl_masked_reg.sv */
// One 32-bit storage register with byte enables and a mask of writable bits.
`timescale 1ns/1ns
module rpl_masked_reg #(
    parameter logic [31:0] WRITE_MASK = 32'hFFFF_FFFF,
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [3:0] sel,
    input wire logic [31:0] wdat,
    output logic [31:0] q
);
    logic [31:0] lane_mask;

    always_comb begin
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & WRITE_MASK;
    end

    // Reserved bits never load, so they keep their cleared reset value.
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RESET_VALUE;
        end else if (we) begin
            q <= (q & ~lane_mask) | (wdat & lane_mask);
        end
    end
endmodule // rpl_masked_reg

/* File: src/rpl_wb_ack.sv */
// Classic Wishbone acknowledge generator: one wait state, ack held for one cycle.
`timescale 1ns/1ns
module rpl_wb_ack (
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc,
    input wire logic stb,
    output logic ack
);
    // Ack falls in the cycle after it rose, so a held request is answered every other cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= cyc & stb & ~ack;
        end
    end
endmodule // rpl_wb_ack

/* File: verification/rpl_regs_bench.sv */
// Self-checking bench for the reference profile level register bank.
`timescale 1ns/1ns
module rpl_regs_bench;
    typedef struct {
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] wdat;
        logic [31:0] exp;
    } rpl_row_t;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic [7:0] lv_b, lv_c, lv_d, lv_e, lv_off, lv_clamp;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    rpl_row_t rows[7];
    logic [11:0] mapped[5] = '{12'h240, 12'h248, 12'h268, 12'h270, 12'h278};

    rpl_regs #(.ADDR_W(12)) u_dut (
        .CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .POINT_B_LEVEL(lv_b), .POINT_C_LEVEL(lv_c),
        .POINT_D_LEVEL(lv_d), .POINT_E_LEVEL(lv_e),
        .SECOND_TURNOFF_LEVEL(lv_off), .SECOND_CLAMP_LEVEL(lv_clamp)
    );

    always #5 CLK = ~CLK;

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Ten thousand cycles is far beyond the roughly 120 the sequence needs.
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 10000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; entered just after a rising edge, holds until ack.
    task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge CLK);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
        @(posedge CLK);
    endtask

    task automatic levels(input logic [47:0] exp);
        @(posedge CLK);
        check({24'h0, lv_b}, {24'h0, exp[47:40]});
        check({24'h0, lv_c}, {24'h0, exp[39:32]});
        check({24'h0, lv_d}, {24'h0, exp[31:24]});
        check({24'h0, lv_e}, {24'h0, exp[23:16]});
        check({24'h0, lv_off}, {24'h0, exp[15:8]});
        check({24'h0, lv_clamp}, {24'h0, exp[7:0]});
    endtask

    task automatic all_cleared();
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, mapped[i], 4'hF, 32'h0000_0000, q);
            check(q, 32'h0000_0000);
        end
        levels(48'h0);
    endtask

    initial begin
        rows[0] = '{12'h278, 4'hF, 32'hFFFF_FFFF, 32'h7FFF_8000};
        rows[1] = '{12'h270, 4'hF, 32'hFFFF_FFFF, 32'h7FFF_FFC0};
        rows[2] = '{12'h268, 4'hF, 32'hFFFF_FFFF, 32'h7FFF_FFFF};
        rows[3] = '{12'h240, 4'hF, 32'hFFFF_FFFF, 32'h7FFF_FFFF};
        rows[4] = '{12'h248, 4'hF, 32'h1234_5678, 32'h1234_5678};
        // The unmapped probe sits outside the fault settings range, which software must not write.
        rows[5] = '{12'hFFC, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000};
        rows[6] = '{12'h270, 4'h3, 32'hA5A5_A5A5, 32'h7FFF_A580};
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        all_cleared();
        // Unmapped words and reserved bits must swallow writes and read zero.
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, rows[i].adr, rows[i].sel, rows[i].wdat, q);
            wb(1'b0, rows[i].adr, 4'hF, 32'h0000_0000, q);
            check(q, rows[i].exp);
        end
        // Distinct field values expose any swapped or shifted field.
        wb(1'b1, 12'h270, 4'hF, 32'hD690_E07F, q);
        wb(1'b1, 12'h268, 4'hF, 32'h0000_0055, q);
        wb(1'b1, 12'h278, 4'hF, 32'h9E70_FFFF, q);
        wb(1'b0, 12'h270, 4'hF, 32'h0000_0000, q);
        check(q, 32'h5690_E040);
        wb(1'b0, 12'h278, 4'hF, 32'h0000_0000, q);
        check(q, 32'h1E70_8000);
        levels(48'hAB_5A_43_81_3C_E1);
        // A reset in mid-run must clear everything again.
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        all_cleared();
        wrap_up();
    end
endmodule // rpl_regs_bench
